//--- core/dip_pkg.sv
// Function
// - Per-input enables for rising and falling edges
// - All edge enables clear after reset
// - Rising is 0-1, falling is 1-0
// - Diagnostic interrupt only for lost edge interrupt
// - One delay setting per group of four
// - Delays 0.1 ms, 0.5 ms, 3 ms, 15 ms
// - Shortest delay only on fast inputs
// - Slow inputs use 0.5 ms at shortest
// - Fast inputs 0,1,3,4,6,7,9,10,11,15
// - Input bytes at addresses 136 and 137
// - Each input drives its own status LED
package dip_pkg;

  // Channel layout
  localparam int NCH        = 16;
  localparam int NGRP       = 4;
  localparam int GRP_SIZE   = 4;
  localparam logic [15:0] FAST_MASK = 16'h8edb;

  // Clock and delay times
  localparam int CLK_KHZ     = 40_000;
  localparam int DLY_100_US  = 100;
  localparam int DLY_500_US  = 500;
  localparam int DLY_3MS_US  = 3_000;
  localparam int DLY_15MS_US = 15_000;
  localparam int DLY_100_CYC = (DLY_100_US * CLK_KHZ + 999) / 1000;
  localparam int DLY_500_CYC = (DLY_500_US * CLK_KHZ + 999) / 1000;
  localparam int DLY_3MS_CYC = (DLY_3MS_US * CLK_KHZ + 999) / 1000;
  localparam int DLY_15MS_CYC = (DLY_15MS_US * CLK_KHZ + 999) / 1000;
  localparam int DLY_CNT_W   = 20;

  // Delay setting codes
  typedef enum logic [1:0] {
    DLY_0P1MS = 2'h0,
    DLY_0P5MS = 2'h1,
    DLY_3MS   = 2'h2,
    DLY_15MS  = 2'h3
  } dip_dly_t;

  // Bus geometry
  localparam int ADR_W = 12;

  // Register byte addresses, with the input bytes from word indices times four
  localparam logic [ADR_W-1:0] ADR_EDGE_EN = 12'h000;
  localparam logic [ADR_W-1:0] ADR_DLY_CFG = 12'h004;
  localparam logic [ADR_W-1:0] ADR_STATUS  = 12'h008;
  localparam logic [ADR_W-1:0] ADR_MASK    = 12'h00c;
  localparam logic [ADR_W-1:0] IDX_IN_LO   = 12'h088;
  localparam logic [ADR_W-1:0] IDX_IN_HI   = 12'h089;
  localparam logic [ADR_W-1:0] ADR_IN_LO   = 12'(IDX_IN_LO * 4);
  localparam logic [ADR_W-1:0] ADR_IN_HI   = 12'(IDX_IN_HI * 4);

  // Field positions
  localparam int FALL_LSB = 16;
  localparam int LOST_LSB = 16;

  // Reset values
  localparam logic [31:0] EDGE_EN_RST = 32'h0000_0000;
  localparam logic [7:0]  DLY_CFG_RST = 8'h00;
  localparam logic [31:0] MASK_RST    = 32'hffff_ffff;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;

endpackage

//--- core/dip_filter.sv
`timescale 1ns/1ps
// Synchroniser and stability filter for one input
module dip_filter #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             pin_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic                  filt_o
);

  logic             meta_r;
  logic             sync_r;
  logic [CNT_W-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level passes only after staying stable for limit cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= '0;
      filt_o <= 1'b0;
    end else if (sync_r == filt_o) begin
      cnt_r <= '0;
    end else if (cnt_r >= limit_i - 1'b1) begin
      cnt_r  <= '0;
      filt_o <= sync_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule

//--- core/dip_edge.sv
`timescale 1ns/1ps
// Edge detector on the filtered inputs with per-edge enables
module dip_edge #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] filt_i,
  input  wire logic [W-1:0] rise_en_i,
  input  wire logic [W-1:0] fall_en_i,
  output logic      [W-1:0] evt_o
);

  logic [W-1:0] prev_r;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  ////////////////////////////////////////////////////////////////////////
  // Transitions of the filtered level
  always_comb begin
    rise = filt_i & ~prev_r;
    fall = ~filt_i & prev_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Enabled edges become one-cycle events
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r <= '0;
      evt_o  <= '0;
    end else begin
      prev_r <= filt_i;
      evt_o  <= (rise & rise_en_i) | (fall & fall_en_i);
    end
  end

endmodule

//--- core/dip_top.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Sixteen-channel filtered digital input port with edge interrupts
module dip_top
#(
  parameter int DLY_500_CYC_P  = dip_pkg::DLY_500_CYC,
  parameter int DLY_3MS_CYC_P  = dip_pkg::DLY_3MS_CYC,
  parameter int DLY_15MS_CYC_P = dip_pkg::DLY_15MS_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [dip_pkg::NCH-1:0]   din_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [dip_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           irq_o,
  output logic      [dip_pkg::NCH-1:0]   led_o
);

  import dip_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  localparam int CNT_MAX = (1 << DLY_CNT_W) - 1;

  if (DLY_500_CYC_P < 1 || DLY_500_CYC_P > CNT_MAX ||
      DLY_3MS_CYC_P < 1 || DLY_3MS_CYC_P > CNT_MAX ||
      DLY_15MS_CYC_P < 1 || DLY_15MS_CYC_P > CNT_MAX) begin : g_bad_dly
    $error("dip_top: delay count out of counter range");
  end

  if (NGRP * GRP_SIZE != NCH) begin : g_bad_grp
    $error("dip_top: groups do not cover all channels");
  end

  // Register halves and input bytes are laid out for sixteen channels
  if (NCH != 16) begin : g_bad_nch
    $error("dip_top: register layout needs sixteen channels");
  end

  // Delay settings must rise in order
  if (DLY_500_CYC_P >= DLY_3MS_CYC_P ||
      DLY_3MS_CYC_P >= DLY_15MS_CYC_P) begin : g_bad_order
    $error("dip_top: delay settings out of order");
  end

  localparam logic [DLY_CNT_W-1:0] LIM_100 = DLY_CNT_W'(DLY_100_CYC);
  localparam logic [DLY_CNT_W-1:0] LIM_500 = DLY_CNT_W'(DLY_500_CYC_P);
  localparam logic [DLY_CNT_W-1:0] LIM_3MS = DLY_CNT_W'(DLY_3MS_CYC_P);
  localparam logic [DLY_CNT_W-1:0] LIM_15MS = DLY_CNT_W'(DLY_15MS_CYC_P);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Filter length for a delay code and channel speed
  function automatic logic [DLY_CNT_W-1:0] dly_limit(
    input logic [1:0] code,
    input logic       fast
  );
    logic [DLY_CNT_W-1:0] lim;
    lim = LIM_15MS;
    unique case (dip_dly_t'(code))
      DLY_0P1MS: lim = fast ? LIM_100 : LIM_500;
      DLY_0P5MS: lim = LIM_500;
      DLY_3MS:   lim = LIM_3MS;
      DLY_15MS:  lim = LIM_15MS;
    endcase
    return lim;
  endfunction

  // Byte lane select widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    logic [31:0] m;
    m = lane_mask(sel);
    return (old & ~m) | (dat & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]          edge_en_r;
  logic [7:0]           dly_cfg_r;
  logic [31:0]          mask_r;
  logic [31:0]          status_r;
  logic [31:0]          status_nxt;
  logic [31:0]          rd_nxt;
  logic [31:0]          clr;
  logic [NCH-1:0]       filt;
  logic [NCH-1:0]       evt;
  logic [NCH-1:0]       lost_set;
  logic                 req;
  logic                 commit;
  logic                 wr;
  logic                 wr_edge_en;
  logic                 wr_dly_cfg;
  logic                 wr_mask;
  logic                 wr_status;
  logic [NCH-1:0]       rise_en;
  logic [NCH-1:0]       fall_en;
  logic [31:0]          pend;
  logic [7:0]           in_lo;
  logic [7:0]           in_hi;

  ////////////////////////////////////////////////////////////////////////
  // Input channels: synchroniser and delay filter per pin
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [DLY_CNT_W-1:0] limit;

    // Group of four shares one delay code
    assign limit = dly_limit(dly_cfg_r[(c / GRP_SIZE) * 2 +: 2],
                             FAST_MASK[c]);

    dip_filter #(
      .CNT_W (DLY_CNT_W)
    ) u_filt (
      .clk     (clk),
      .rst     (rst),
      .pin_i   (din_i[c]),
      .limit_i (limit),
      .filt_o  (filt[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable halves: rising in the low half, falling in the high half
  always_comb begin
    rise_en = edge_en_r[NCH-1:0];
    fall_en = edge_en_r[FALL_LSB +: NCH];
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge events from filtered levels
  dip_edge #(
    .W (NCH)
  ) u_edge (
    .clk       (clk),
    .rst       (rst),
    .filt_i    (filt),
    .rise_en_i (rise_en),
    .fall_en_i (fall_en),
    .evt_o     (evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Wishbone handshake: ack one cycle after request, commit on ack
  always_comb begin
    req    = wb_cyc_i & wb_stb_i;
    commit = req & wb_ack_o;
    wr     = commit & wb_we_i;
  end

  // Per-register write strobes, true only at the ack edge
  always_comb begin
    wr_edge_en = wr && (wb_adr_i == ADR_EDGE_EN);
    wr_dly_cfg = wr && (wb_adr_i == ADR_DLY_CFG) && wb_sel_i[0];
    wr_mask    = wr && (wb_adr_i == ADR_MASK);
    wr_status  = wr && (wb_adr_i == ADR_STATUS);
  end

  // One ack pulse per request; a held request waits a cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input bytes as software sees them: filtered levels
  always_comb begin
    in_lo = filt[7:0];
    in_hi = filt[15:8];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data mux, captured when the request is first seen
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_EDGE_EN: rd_nxt = edge_en_r;
      ADR_DLY_CFG: rd_nxt = {24'h00_0000, dly_cfg_r};
      ADR_STATUS:  rd_nxt = status_r;
      ADR_MASK:    rd_nxt = mask_r;
      ADR_IN_LO:   rd_nxt = {24'h00_0000, in_lo};
      ADR_IN_HI:   rd_nxt = {24'h00_0000, in_hi};
      default:     rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data held from the request edge until the next request
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o) begin
      wb_dat_o <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge enables, all off after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_en_r <= EDGE_EN_RST;
    end else if (wr_edge_en) begin
      edge_en_r <= merge(edge_en_r, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Group delay codes, two bits per group
  always_ff @(posedge clk) begin
    if (rst) begin
      dly_cfg_r <= DLY_CFG_RST;
    end else if (wr_dly_cfg) begin
      dly_cfg_r <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt mask
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= merge(mask_r, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-one-to-clear bits, only at the ack edge of a status write
  always_comb begin
    clr = 32'h0000_0000;
    if (wr_status) begin
      clr = wb_dat_i & lane_mask(wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event on a still pending edge means an interrupt was lost
  always_comb begin
    lost_set = evt & status_r[NCH-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Next status: a new event wins over a clear in the same cycle
  always_comb begin
    status_nxt[NCH-1:0] = (status_r[NCH-1:0] & ~clr[NCH-1:0]) | evt;
    status_nxt[LOST_LSB +: NCH] =
      (status_r[LOST_LSB +: NCH] & ~clr[LOST_LSB +: NCH]) | lost_set;
  end

  // Sticky status: edge events low half, lost flags high half
  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unmasked bits of the next status, so irq_o tracks it without lag
  always_comb begin
    pend = status_nxt & mask_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt output, high while an unmasked status bit is set
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status LEDs follow the filtered input levels
  always_ff @(posedge clk) begin
    if (rst) begin
      led_o <= '0;
    end else begin
      led_o <= filt;
    end
  end

endmodule

//--- tb/dip_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Port checker for the filtered input port
module dip_properties (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic [dip_pkg::NCH-1:0]   din_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [dip_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      irq_o,
  input wire logic [dip_pkg::NCH-1:0]   led_o
);
  import dip_pkg::*;
  logic mapped;

  // Byte addresses that decode to a register
  assign mapped = wb_adr_i inside {ADR_EDGE_EN, ADR_DLY_CFG, ADR_STATUS,
                                   ADR_MASK, ADR_IN_LO, ADR_IN_HI};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Bus steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  sequence s_mask_off;
    wb_ack_o && wb_we_i && wb_adr_i == ADR_MASK && wb_sel_i == 4'hf
      && wb_dat_i == 32'h0;
  endsequence

  chk_ack_after_req:
    assert property (s_req |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
  chk_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
  chk_ack_has_req:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
  chk_unmapped_zero:
    assert property (s_rd ##0 !mapped |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
  chk_byte_lo_read:
    assert property (s_rd ##0 wb_adr_i == ADR_IN_LO
                     |-> wb_dat_o == {24'h0, led_o[7:0]})
      else $error("low input byte wrong");
  chk_byte_hi_read:
    assert property (s_rd ##0 wb_adr_i == ADR_IN_HI
                     |-> wb_dat_o == {24'h0, led_o[15:8]})
      else $error("high input byte wrong");
  chk_led_rise_filtered:
    assert property (|(led_o & ~$past(led_o))
                     |-> (led_o & ~$past(led_o) & ~$past(din_i, 8)) == 16'h0)
      else $error("led rose without stable high input");
  chk_led_fall_filtered:
    assert property (|(~led_o & $past(led_o))
                     |-> (~led_o & $past(led_o) & $past(din_i, 8)) == 16'h0)
      else $error("led fell without stable low input");
  chk_mask_gates_irq:
    assert property (s_mask_off |-> ##2 !irq_o [*2])
      else $error("irq high with mask cleared");
endmodule

//--- tb/dip_sensor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Field sensors: steady levels, or chatter faster than any filter
module dip_sensor (
  input  wire logic        clk,
  input  wire logic [15:0] lvl_i,
  input  wire logic        chat_i,
  output logic      [15:0] din_o
);
  initial din_o = 16'h0000;
  // Pins move just after the clock edge
  always @(posedge clk) begin
    din_o <= chat_i ? ~din_o : lvl_i;
  end
endmodule

//--- tb/test_digital_input_port_edge_irq.sv
`timescale 1ns/1ps
module test_digital_input_port_edge_irq;
  import dip_pkg::*;
  logic             clk;
  logic             rst;
  logic             cyc;
  logic             stb;
  logic             we;
  logic             chat;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [3:0]       wsel;
  logic [31:0]      dat;
  logic [31:0]      dat_o;
  logic             ack;
  logic             irq;
  logic [15:0]      lvl;
  logic [15:0]      din;
  logic [15:0]      led;
  int               fail_count;
  int               n_tests;

  dip_sensor sensor (.clk(clk), .lvl_i(lvl), .chat_i(chat), .din_o(din));
  dip_top #(.DLY_500_CYC_P(20), .DLY_3MS_CYC_P(40), .DLY_15MS_CYC_P(60))
  dut (.clk(clk), .rst(rst), .din_i(din), .wb_cyc_i(cyc), .wb_stb_i(stb),
       .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
       .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .led_o(led));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= wsel;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("wb_ack", 32'h1, {31'h0, ack});
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [ADR_W-1:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd("edge_en", ADR_EDGE_EN, 32'h0);
    rd("dly_cfg", ADR_DLY_CFG, 32'h0);
    rd("status", ADR_STATUS, 32'h0);
    rd("mask", ADR_MASK, MASK_RST);
    rd("unmapped", 12'h100, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  // Groups 0..3 get codes 0..3; all pins rise together
  task automatic t_delays();
    wr(ADR_DLY_CFG, 32'h0000_00e4);
    lvl <= 16'hffff;
    wt(30);
    chk("led_20", 32'h00f4, {16'h0, led});
    wt(20);
    chk("led_40", 32'h0ff4, {16'h0, led});
    wt(20);
    chk("led_60", 32'hfff4, {16'h0, led});
    rd("in_lo", ADR_IN_LO, 32'hf4);
    rd("in_hi", ADR_IN_HI, 32'hff);
    wr(ADR_IN_LO, 32'h0);
    rd("in_lo_ro", ADR_IN_LO, 32'hf4);
    wt(3850);
    chk("led_3900", 32'hfff4, {16'h0, led});
    wt(150);
    chk("led_4000", 32'hffff, {16'h0, led});
    rd("status_off", ADR_STATUS, 32'h0);
  endtask
  task automatic t_chatter();
    chat <= 1'b1;
    wt(30);
    chat <= 1'b0;
    wt(30);
    chk("led_chat", 32'hffff, {16'h0, led});
  endtask
  // Rise enabled on input 4, fall enabled on input 5
  task automatic t_edges();
    wr(ADR_EDGE_EN, 32'h0020_0010);
    lvl <= 16'hffcf;
    wt(40);
    rd("st_fall", ADR_STATUS, 32'h20);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(ADR_MASK, 32'h0);
    wt(3);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(ADR_MASK, MASK_RST);
    wr(ADR_STATUS, 32'h20);
    wt(3);
    rd("st_clr", ADR_STATUS, 32'h0);
    lvl <= 16'hffdf;
    wt(40);
    rd("st_rise", ADR_STATUS, 32'h10);
    lvl <= 16'hffcf;
    wt(40);
    lvl <= 16'hffdf;
    wt(40);
    rd("st_lost", ADR_STATUS, 32'h0010_0010);
    chk("irq_lost", 32'h1, {31'h0, irq});
    wr(ADR_STATUS, 32'hffff_ffff);
    wt(3);
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask

  // Byte lanes: partial mask write, delay write without lane 0
  task automatic t_lanes();
    wsel = 4'h1;
    wr(ADR_MASK, 32'h0);
    rd("mask_lane", ADR_MASK, 32'hffff_ff00);
    wsel = 4'h2;
    wr(ADR_DLY_CFG, 32'hffff_ffff);
    rd("dly_lane", ADR_DLY_CFG, 32'h0);
    wsel = 4'hf;
    wr(ADR_MASK, MASK_RST);
    rd("mask_back", ADR_MASK, MASK_RST);
  endtask
  // Reset in mid-run: enables clear, delay codes back to the shortest
  task automatic t_rerst();
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    rd("edge_en_rst", ADR_EDGE_EN, 32'h0);
    wt(80);
    chk("led_rst", {16'h0, 16'hffdf & ~FAST_MASK}, {16'h0, led});
    rd("status_rst", ADR_STATUS, 32'h0);
    chk("irq_rst", 32'h0, {31'h0, irq});
  endtask

  // Main sequence
  initial begin
    fail_count = 0;
    n_tests = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    chat = 1'b0;
    adr = '0;
    sel = 4'hf;
    wsel = 4'hf;
    dat = '0;
    lvl = 16'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lanes();
    t_delays();
    t_chatter();
    t_edges();
    t_rerst();
    report_and_stop();
  end
  // Watchdog, well beyond the 4500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule

bind dip_top dip_properties chk_i (
  .clk(clk), .rst(rst), .din_i(din_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .led_o(led_o));
